// file: core/rail_fault_pkg.sv
package rail_fault_pkg;
	// Clock and qualification timing
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned OV_DELAY_NS = 1000;
	localparam int unsigned UV_DELAY_NS = 3000;
	localparam int unsigned LOCKOUT_DELAY_NS = 3000;
	localparam int unsigned ACTION_DELAY_NS = 10000;
	localparam int unsigned TON_NS = 400;
	// Least times round up to whole cycles
	localparam int unsigned OV_DELAY_CYC = (OV_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned UV_DELAY_CYC = (UV_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned LOCKOUT_DELAY_CYC = (LOCKOUT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned ACTION_DELAY_CYC = (ACTION_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TON_CYC = (TON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Current monitor conversion, voltages in microvolts
	localparam int unsigned MON_LSB_UV = 6250;
	localparam int unsigned MON_FULL_UV = 3193750;
	localparam logic [8:0] MON_MAX_CODE = 9'h1FF;
	localparam logic [8:0] MON_RESET_CODE = 9'h000;
	// Requested voltage code standing for 0.9 V
	localparam logic [7:0] VID_0V9_CODE = 8'h5A;
	// Synchronised comparator input positions
	localparam int unsigned SYNC_W = 11;
	localparam int unsigned S_EN = 0;
	localparam int unsigned S_OFS_LOW = 1;
	localparam int unsigned S_OV_FIXED = 2;
	localparam int unsigned S_OV_REF = 3;
	localparam int unsigned S_NEG = 4;
	localparam int unsigned S_UV = 5;
	localparam int unsigned S_SUPPLY_LOW = 6;
	localparam int unsigned S_TDC = 7;
	localparam int unsigned S_SPIKE = 8;
	localparam int unsigned S_STILL_OVER = 9;
	localparam int unsigned S_FAST = 10;
	// Phases and over-current sequencing
	localparam int unsigned PHASES = 2;
	typedef enum logic [1:0] {OCP_IDLE, OCP_DELAY, OCP_OFF} ocp_state_t;
endpackage

// file: core/persist_filter.sv
`timescale 1ns/1ps
module persist_filter #(
	parameter int unsigned CYCLES = 50
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Level to qualify
	input wire logic level,
	output logic qualified
);
	localparam int W = $clog2(CYCLES + 1);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;

	// Count consecutive cycles of the level, saturating
	assign cnt_nxt = !level ? '0 : (cnt_r == W'(CYCLES)) ? cnt_r : cnt_r + 1'b1;
	assign qualified = (cnt_r == W'(CYCLES));

	// Run counter
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule // persist_filter

// file: core/current_code_store.sv
`timescale 1ns/1ps
module current_code_store (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Conversion result in
	input wire logic sample_valid,
	input wire logic [21:0] monitor_uv,
	// Output current register
	output logic [8:0] current_code_r,
	output logic current_update_r
);
	logic [21:0] quot;
	logic [8:0] code_nxt;

	// Divide into 6.25 mV steps, clamp at full scale
	assign quot = monitor_uv / 22'(rail_fault_pkg::MON_LSB_UV);
	assign code_nxt = (monitor_uv >= 22'(rail_fault_pkg::MON_FULL_UV)) ? rail_fault_pkg::MON_MAX_CODE : quot[8:0];

	// Store each result
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			current_code_r <= rail_fault_pkg::MON_RESET_CODE;
			current_update_r <= 1'b0;
		end else begin
			current_update_r <= sample_valid;
			if (sample_valid) begin
				current_code_r <= code_nxt;
			end
		end
	end
endmodule // current_code_store

// file: core/rail_fault_protection_logic.sv
`timescale 1ns/1ps
// Overview of operation
// - Sample offset at enable rise; low disables offset
// - Upward voltage step forces two-phase mode
// - Downward voltage step holds present operating state
// - Monitor zero to 3.19375V maps codes 0 to 511
// - Each conversion result lands in current register
// - Fast response pulse overrides every active on-time
// - Current trip asserts alert, starts action delay
// - Delay expired, still over: all switches off
// - Low code: over-voltage at fixed 1.225V level
// - High code: reference plus 325mV, latched trip
// - Over-voltage latch: low-side on, high-side off
// - Over-voltage latch requests other rail shutdown
// - Over-voltage condition must persist 1us
// - Negative rail under latch: low-sides off too
// - Rail back above zero: low-sides on again
// - Negative detection only while over-voltage latched
// - Rail 500mV below reference sets under-voltage latch
// - Under-voltage latch holds all switches off
// - Under-voltage latch requests other rail shutdown
// - Under-voltage condition must persist 3us
// - Supply lockout after 3us forces switches off
// - Over-voltage watch starts after power-on reset
module rail_fault_protection_logic (
	// Clock and power-on reset
	input wire logic core_clk,
	input wire logic rstn,
	// Asynchronous enable and comparator levels
	input wire logic enable_pin,
	input wire logic offset_input_pin_low,
	input wire logic ov_fixed_cmp,
	input wire logic ov_ref_cmp,
	input wire logic negative_rail_cmp,
	input wire logic uv_ref_cmp,
	input wire logic supply_low_cmp,
	input wire logic averaged_current_trip,
	input wire logic spike_current_trip,
	input wire logic current_still_over_cmp,
	input wire logic fast_response_cmp,
	// Same-clock control
	input wire logic [7:0] requested_voltage_code,
	input wire logic step_up_req,
	input wire logic step_down_req,
	input wire logic step_done,
	input wire logic two_phase_req,
	input wire logic [1:0] pwm_hs,
	input wire logic [1:0] pwm_ls,
	// Current monitor conversion
	input wire logic monitor_valid,
	input wire logic [21:0] current_monitor_uv,
	// Gate drive
	output logic [1:0] hs_on,
	output logic [1:0] ls_on,
	output logic [1:0] on_time_override,
	// Status and cross-rail
	output logic overcurrent_alert_n,
	output logic soft_shutdown_req,
	output logic fast_response_pulse,
	output logic initial_offset_en_r,
	output logic two_phase_r,
	output logic over_voltage_latch_r,
	output logic under_voltage_latch_r,
	output logic negative_voltage_trip,
	output logic supply_lockout,
	output logic [8:0] output_current_r,
	output logic output_current_update_r
);
	localparam int TON_A = rail_fault_pkg::TON_CYC;
	localparam int ACT_W = $clog2(rail_fault_pkg::ACTION_DELAY_CYC + 1);
	localparam int TON_W = $clog2(rail_fault_pkg::TON_CYC + 1);

	// Phase mask decode, used for both switch sides
	function automatic logic [1:0] active_mask(input logic two_phase);
		active_mask = {two_phase, 1'b1};
	endfunction

	logic [rail_fault_pkg::SYNC_W-1:0] async_in;
	wire logic [rail_fault_pkg::SYNC_W-1:0] sync_r;
	logic en_s;
	logic en_d_r;
	logic en_rise;
	logic por_done_r;
	logic ov_cond;
	logic ov_qual;
	logic uv_qual;
	logic lockout_qual;
	logic trip_any;
	logic fast_d_r;
	logic [TON_W-1:0] ton_cnt_r;
	logic [ACT_W-1:0] act_cnt_r;
	logic [ACT_W-1:0] act_cnt_nxt;
	logic step_hold_r;
	logic ocp_off;
	logic all_off;
	logic [1:0] mask;
	rail_fault_pkg::ocp_state_t ocp_r;
	rail_fault_pkg::ocp_state_t ocp_nxt;

	// Gather comparator pins for synchronising
	assign async_in = {fast_response_cmp, current_still_over_cmp, spike_current_trip, averaged_current_trip,
		supply_low_cmp, uv_ref_cmp, negative_rail_cmp, ov_ref_cmp, ov_fixed_cmp, offset_input_pin_low, enable_pin};

	// Two-flop synchronisers per comparator
	genvar gi;
	generate
		for (gi = 0; gi < rail_fault_pkg::SYNC_W; gi++) begin : g_sync
			logic meta_bit_r;
			logic sync_bit_r;
			always_ff @(posedge core_clk or negedge rstn) begin
				if (!rstn) begin
					meta_bit_r <= 1'b0;
					sync_bit_r <= 1'b0;
				end else begin
					meta_bit_r <= async_in[gi];
					sync_bit_r <= meta_bit_r;
				end
			end
			assign sync_r[gi] = sync_bit_r;
		end
	endgenerate

	// Enable edge
	assign en_s = sync_r[rail_fault_pkg::S_EN];
	assign en_rise = en_s && !en_d_r;

	// Over-voltage threshold select by requested code
	assign ov_cond = por_done_r && en_s && ((requested_voltage_code < rail_fault_pkg::VID_0V9_CODE) ?
		sync_r[rail_fault_pkg::S_OV_FIXED] : sync_r[rail_fault_pkg::S_OV_REF]);

	// Persistence filters
	persist_filter #(.CYCLES(rail_fault_pkg::OV_DELAY_CYC)) u_ov_filt (
		.core_clk(core_clk),
		.rstn(rstn),
		.level(ov_cond),
		.qualified(ov_qual)
	);
	persist_filter #(.CYCLES(rail_fault_pkg::UV_DELAY_CYC)) u_uv_filt (
		.core_clk(core_clk),
		.rstn(rstn),
		.level(sync_r[rail_fault_pkg::S_UV] && en_s),
		.qualified(uv_qual)
	);
	persist_filter #(.CYCLES(rail_fault_pkg::LOCKOUT_DELAY_CYC)) u_lo_filt (
		.core_clk(core_clk),
		.rstn(rstn),
		.level(sync_r[rail_fault_pkg::S_SUPPLY_LOW]),
		.qualified(lockout_qual)
	);

	// Output current register
	current_code_store u_store (
		.core_clk(core_clk),
		.rstn(rstn),
		.sample_valid(monitor_valid),
		.monitor_uv(current_monitor_uv),
		.current_code_r(output_current_r),
		.current_update_r(output_current_update_r)
	);

	// Reset, enable and latches
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			por_done_r <= 1'b0;
			en_d_r <= 1'b0;
			initial_offset_en_r <= 1'b0;
			over_voltage_latch_r <= 1'b0;
			under_voltage_latch_r <= 1'b0;
		end else begin
			por_done_r <= 1'b1;
			en_d_r <= en_s;
			if (en_rise) begin
				initial_offset_en_r <= !sync_r[rail_fault_pkg::S_OFS_LOW];
			end
			if (!en_s) begin
				over_voltage_latch_r <= 1'b0;
				under_voltage_latch_r <= 1'b0;
			end else begin
				over_voltage_latch_r <= over_voltage_latch_r || ov_qual;
				under_voltage_latch_r <= under_voltage_latch_r || uv_qual;
			end
		end
	end

	// Negative detection gated by the over-voltage latch
	assign negative_voltage_trip = over_voltage_latch_r && sync_r[rail_fault_pkg::S_NEG];
	assign supply_lockout = lockout_qual;
	assign soft_shutdown_req = over_voltage_latch_r || under_voltage_latch_r;

	// Phase policy on voltage steps
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			two_phase_r <= 1'b0;
			step_hold_r <= 1'b0;
		end else begin
			if (step_up_req) begin
				two_phase_r <= 1'b1;
				step_hold_r <= 1'b1;
			end else if (step_down_req) begin
				step_hold_r <= 1'b1;
			end else if (step_done) begin
				step_hold_r <= 1'b0;
			end else if (!step_hold_r) begin
				two_phase_r <= two_phase_req;
			end
		end
	end

	// Over-current sequencing
	assign trip_any = sync_r[rail_fault_pkg::S_TDC] || sync_r[rail_fault_pkg::S_SPIKE];
	assign act_cnt_nxt = (ocp_r == rail_fault_pkg::OCP_DELAY) ? act_cnt_r + 1'b1 : '0;
	always_comb begin
		ocp_nxt = ocp_r;
		case (ocp_r)
			rail_fault_pkg::OCP_IDLE: begin
				if (trip_any) begin
					ocp_nxt = rail_fault_pkg::OCP_DELAY;
				end
			end
			rail_fault_pkg::OCP_DELAY: begin
				if (act_cnt_r == ACT_W'(rail_fault_pkg::ACTION_DELAY_CYC - 1)) begin
					ocp_nxt = sync_r[rail_fault_pkg::S_STILL_OVER] ? rail_fault_pkg::OCP_OFF :
						rail_fault_pkg::OCP_IDLE;
				end
			end
			rail_fault_pkg::OCP_OFF: ocp_nxt = rail_fault_pkg::OCP_OFF;
			default: ocp_nxt = rail_fault_pkg::OCP_IDLE;
		endcase
		if (!en_s) begin
			ocp_nxt = rail_fault_pkg::OCP_IDLE;
		end
	end
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ocp_r <= rail_fault_pkg::OCP_IDLE;
			act_cnt_r <= '0;
		end else begin
			ocp_r <= ocp_nxt;
			act_cnt_r <= act_cnt_nxt;
		end
	end
	assign overcurrent_alert_n = (ocp_r == rail_fault_pkg::OCP_IDLE);
	assign ocp_off = (ocp_r == rail_fault_pkg::OCP_OFF);

	// Fast response pulse of one nominal on-time
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			fast_d_r <= 1'b0;
			ton_cnt_r <= '0;
		end else begin
			fast_d_r <= sync_r[rail_fault_pkg::S_FAST];
			if (sync_r[rail_fault_pkg::S_FAST] && !fast_d_r && ton_cnt_r == '0) begin
				ton_cnt_r <= TON_W'(rail_fault_pkg::TON_CYC);
			end else if (ton_cnt_r != '0) begin
				ton_cnt_r <= ton_cnt_r - 1'b1;
			end
		end
	end
	assign fast_response_pulse = (ton_cnt_r != '0);
	assign mask = active_mask(two_phase_r);
	assign on_time_override = fast_response_pulse ? mask : 2'h0;

	// Gate drive priority: hard off, then clamp, then normal
	assign all_off = !en_s || supply_lockout || under_voltage_latch_r || ocp_off;
	assign hs_on = (all_off || over_voltage_latch_r) ? 2'h0 : ((pwm_hs | on_time_override) & mask);
	assign ls_on = all_off ? 2'h0 : over_voltage_latch_r ? (negative_voltage_trip ? 2'h0 : mask) :
		(pwm_ls & ~on_time_override & mask);

	// Helper: consecutive over-voltage condition cycles
	logic [7:0] ov_run_r;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ov_run_r <= 8'h00;
		end else begin
			ov_run_r <= !ov_cond ? 8'h00 : (ov_run_r == 8'hFF) ? ov_run_r : ov_run_r + 8'h01;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	sequence trip_seen;
		!overcurrent_alert_n && ocp_r == rail_fault_pkg::OCP_DELAY;
	endsequence

	offset_sample_a: assert property (en_rise |=>
		initial_offset_en_r == !$past(sync_r[rail_fault_pkg::S_OFS_LOW]))
		else $error("offset enable not sampled at enable rise");
	step_up_a: assert property (step_up_req |=> two_phase_r)
		else $error("step up did not force two phases");
	step_hold_a: assert property (step_down_req && !step_up_req |=> $stable(two_phase_r))
		else $error("step down changed phase count");
	fast_width_a: assert property ($rose(fast_response_pulse) |-> ##TON_A !fast_response_pulse)
		else $error("fast response pulse width wrong");
	alert_raise_a: assert property (overcurrent_alert_n && trip_any && en_s |=> trip_seen)
		else $error("current trip did not raise alert");
	ocp_off_a: assert property (ocp_off |-> hs_on == 2'h0 && ls_on == 2'h0)
		else $error("switches on after over-current shutoff");
	ov_clamp_a: assert property (over_voltage_latch_r && !all_off && !negative_voltage_trip
		|-> ls_on == mask && hs_on == 2'h0)
		else $error("over-voltage clamp not applied");
	shutdown_req_a: assert property ($rose(over_voltage_latch_r) || $rose(under_voltage_latch_r)
		|-> soft_shutdown_req)
		else $error("no shutdown request on latch");
	ov_persist_a: assert property ($rose(over_voltage_latch_r) |->
		$past(ov_run_r) >= 8'(rail_fault_pkg::OV_DELAY_CYC))
		else $error("over-voltage latched too early");
	nv_off_a: assert property (negative_voltage_trip |-> ls_on == 2'h0 && hs_on == 2'h0)
		else $error("switch on during negative trip");
	nv_gate_a: assert property (!over_voltage_latch_r |-> !negative_voltage_trip)
		else $error("negative trip without over-voltage latch");
	uv_off_a: assert property (under_voltage_latch_r |-> hs_on == 2'h0 && ls_on == 2'h0)
		else $error("switch on during under-voltage latch");
	lockout_off_a: assert property (supply_lockout |-> hs_on == 2'h0 && ls_on == 2'h0)
		else $error("switch on during supply lockout");
	latch_clear_a: assert property (!en_s |=> !over_voltage_latch_r && !under_voltage_latch_r)
		else $error("latches not cleared by disable");
endmodule // rail_fault_protection_logic

// file: test/gate_stage_model.sv
`timescale 1ns/1ps
module gate_stage_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Switch commands from the block
	input wire logic [1:0] hs_on,
	input wire logic [1:0] ls_on,
	input wire logic soft_shutdown_req,
	// Modulator requests towards the block
	output logic [1:0] pwm_hs,
	output logic [1:0] pwm_ls,
	// Observations for the bench
	output logic [15:0] overlap_count,
	output logic shutdown_seen
);
	logic [3:0] phase_cnt_r;

	// Ten-cycle switching period, one idle cycle as dead time
	assign pwm_hs = (phase_cnt_r < 4'h3) ? 2'h3 : 2'h0;
	assign pwm_ls = (phase_cnt_r > 4'h3) ? 2'h3 : 2'h0;

	// Period counter, shoot-through tally and companion rail shutdown
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			phase_cnt_r <= 4'h0;
			overlap_count <= 16'h0000;
			shutdown_seen <= 1'b0;
		end else begin
			phase_cnt_r <= (phase_cnt_r == 4'h9) ? 4'h0 : phase_cnt_r + 4'h1;
			if ((hs_on & ls_on) != 2'h0) begin
				overlap_count <= overlap_count + 16'h0001;
			end
			if (soft_shutdown_req) begin
				shutdown_seen <= 1'b1;
			end
		end
	end
endmodule // gate_stage_model

// file: test/tb_rail_fault_protection_logic.sv
`timescale 1ns/1ps
module tb_rail_fault_protection_logic;
	logic core_clk = 1'b0, rstn = 1'b0, enable_pin = 1'b0, offset_input_pin_low = 1'b0;
	logic ov_fixed_cmp = 1'b0, ov_ref_cmp = 1'b0, negative_rail_cmp = 1'b0, uv_ref_cmp = 1'b0;
	logic supply_low_cmp = 1'b0, averaged_current_trip = 1'b0, spike_current_trip = 1'b0;
	logic current_still_over_cmp = 1'b0, fast_response_cmp = 1'b0, two_phase_req = 1'b0;
	logic step_up_req = 1'b0, step_down_req = 1'b0, step_done = 1'b0, monitor_valid = 1'b0;
	logic [7:0] requested_voltage_code = 8'h40;
	logic [21:0] current_monitor_uv = 22'h000000;
	logic [1:0] pwm_hs, pwm_ls, hs_on, ls_on, on_time_override;
	logic overcurrent_alert_n, soft_shutdown_req, fast_response_pulse, initial_offset_en_r, two_phase_r;
	logic over_voltage_latch_r, under_voltage_latch_r, negative_voltage_trip, supply_lockout;
	logic output_current_update_r, shutdown_seen;
	logic [8:0] output_current_r;
	logic [15:0] overlap_count;
	int fail_count = 0, comparisons = 0;

	// Clock
	always #10 core_clk = ~core_clk;

	rail_fault_protection_logic uut (.core_clk(core_clk), .rstn(rstn), .enable_pin(enable_pin),
		.offset_input_pin_low(offset_input_pin_low), .ov_fixed_cmp(ov_fixed_cmp), .ov_ref_cmp(ov_ref_cmp),
		.negative_rail_cmp(negative_rail_cmp), .uv_ref_cmp(uv_ref_cmp), .supply_low_cmp(supply_low_cmp),
		.averaged_current_trip(averaged_current_trip), .spike_current_trip(spike_current_trip),
		.current_still_over_cmp(current_still_over_cmp), .fast_response_cmp(fast_response_cmp),
		.requested_voltage_code(requested_voltage_code), .step_up_req(step_up_req),
		.step_down_req(step_down_req), .step_done(step_done), .two_phase_req(two_phase_req),
		.pwm_hs(pwm_hs), .pwm_ls(pwm_ls), .monitor_valid(monitor_valid),
		.current_monitor_uv(current_monitor_uv), .hs_on(hs_on), .ls_on(ls_on),
		.on_time_override(on_time_override), .overcurrent_alert_n(overcurrent_alert_n),
		.soft_shutdown_req(soft_shutdown_req), .fast_response_pulse(fast_response_pulse),
		.initial_offset_en_r(initial_offset_en_r), .two_phase_r(two_phase_r),
		.over_voltage_latch_r(over_voltage_latch_r), .under_voltage_latch_r(under_voltage_latch_r),
		.negative_voltage_trip(negative_voltage_trip), .supply_lockout(supply_lockout),
		.output_current_r(output_current_r), .output_current_update_r(output_current_update_r));

	gate_stage_model partner (.core_clk(core_clk), .rstn(rstn), .hs_on(hs_on), .ls_on(ls_on),
		.soft_shutdown_req(soft_shutdown_req), .pwm_hs(pwm_hs), .pwm_ls(pwm_ls),
		.overlap_count(overlap_count), .shutdown_seen(shutdown_seen));

	// Shared helpers
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic chk(input string name, input logic [21:0] exp, input logic [21:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Enable low then high clears every latch
	task automatic clear_latches();
		enable_pin = 1'b0;
		cyc(6);
		enable_pin = 1'b1;
		cyc(6);
		chk("latches cleared", 22'h0, {over_voltage_latch_r, under_voltage_latch_r});
	endtask

	// Offset level taken only at enable rise
	task automatic offset_test();
		offset_input_pin_low = 1'b1;
		enable_pin = 1'b1;
		cyc(6);
		chk("offset low", 22'h0, initial_offset_en_r);
		offset_input_pin_low = 1'b0;
		cyc(6);
		chk("offset after edge", 22'h0, initial_offset_en_r);
		clear_latches();
		offset_input_pin_low = 1'b1;
		cyc(6);
		chk("offset high", 22'h1, initial_offset_en_r);
		offset_input_pin_low = 1'b0;
	endtask

	task automatic step(input int k);
		case (k)
			0: step_up_req = 1'b1;
			1: step_down_req = 1'b1;
			default: step_done = 1'b1;
		endcase
		cyc(1);
		{step_up_req, step_down_req, step_done} = 3'h0;
		cyc(2);
	endtask

	// Phase policy under voltage steps
	task automatic step_test();
		step(0);
		chk("step up phases", 22'h1, two_phase_r);
		step(1);
		step(2);
		chk("after done", 22'h0, two_phase_r);
		step(1);
		two_phase_req = 1'b1;
		cyc(3);
		chk("step down hold", 22'h0, two_phase_r);
		step(2);
		chk("hold released", 22'h1, two_phase_r);
		two_phase_req = 1'b0;
		cyc(2);
		chk("single phase", 22'h0, two_phase_r);
	endtask

	// Conversion codes at the boundaries
	task automatic current_test();
		logic [21:0] uvs [5];
		logic [8:0] codes [5];
		logic upd;
		uvs = '{22'h000000, 22'h00186A, 22'h30BB95, 22'h30BB96, 22'h3D0900};
		codes = '{9'h000, 9'h001, 9'h1FE, 9'h1FF, 9'h1FF};
		uvs[0] = 22'h001869;
		for (int i = 0; i < 5; i++) begin
			monitor_valid = 1'b1;
			current_monitor_uv = uvs[i];
			cyc(1);
			upd = output_current_update_r;
			monitor_valid = 1'b0;
			cyc(1);
			upd = upd | output_current_update_r;
			chk("current code", codes[i], output_current_r);
			chk("current update", 22'h1, upd);
		end
	endtask

	// Fast pulse width and override mask
	task automatic fast_test();
		int n;
		logic [1:0] ovr;
		n = 0;
		ovr = 2'h0;
		fast_response_cmp = 1'b1;
		repeat (40) begin
			cyc(1);
			if (fast_response_pulse === 1'b1) begin
				n++;
				ovr = on_time_override;
			end
		end
		fast_response_cmp = 1'b0;
		chk("fast pulse cycles", 22'(rail_fault_pkg::TON_CYC), n);
		chk("override mask", 22'h1, ovr);
	endtask

	// Spike with current still over, then averaged trip that recovers
	task automatic ocp_test();
		for (int i = 0; i < 2; i++) begin
			{spike_current_trip, averaged_current_trip} = (i == 0) ? 2'h2 : 2'h1;
			current_still_over_cmp = (i == 0);
			cyc(3);
			{spike_current_trip, averaged_current_trip} = 2'h0;
			cyc(3);
			chk("alert on trip", 22'h0, overcurrent_alert_n);
			cyc(400);
			chk("alert in delay", 22'h0, overcurrent_alert_n);
			cyc(110);
			chk("alert after delay", (i == 0) ? 22'h0 : 22'h1, overcurrent_alert_n);
			if (i == 0) chk("ocp switches", 22'h0, {hs_on, ls_on});
			current_still_over_cmp = 1'b0;
			clear_latches();
		end
	endtask

	// Over-voltage with filter, clamp and negative recovery
	task automatic ov_case(input logic [7:0] code, input bit use_ref);
		requested_voltage_code = code;
		negative_rail_cmp = 1'b1;
		cyc(5);
		chk("negative unlatched", 22'h0, negative_voltage_trip);
		negative_rail_cmp = 1'b0;
		{ov_ref_cmp, ov_fixed_cmp} = use_ref ? 2'h1 : 2'h2;
		cyc(80);
		chk("wrong threshold", 22'h0, over_voltage_latch_r);
		{ov_ref_cmp, ov_fixed_cmp} = use_ref ? 2'h2 : 2'h1;
		cyc(40);
		{ov_ref_cmp, ov_fixed_cmp} = 2'h0;
		cyc(5);
		chk("ov glitch", 22'h0, over_voltage_latch_r);
		{ov_ref_cmp, ov_fixed_cmp} = use_ref ? 2'h2 : 2'h1;
		cyc(60);
		{ov_ref_cmp, ov_fixed_cmp} = 2'h0;
		cyc(5);
		chk("ov latch", 22'h1, over_voltage_latch_r);
		chk("ov shutdown", 22'h1, soft_shutdown_req);
		chk("ov clamp", 22'h1, {hs_on, ls_on});
		negative_rail_cmp = 1'b1;
		cyc(4);
		chk("negative off", 22'h0, {hs_on, ls_on});
		negative_rail_cmp = 1'b0;
		cyc(4);
		chk("negative recover", 22'h1, {hs_on, ls_on});
		clear_latches();
	endtask

	// Under-voltage latch and supply lockout
	task automatic uv_lock_test();
		uv_ref_cmp = 1'b1;
		cyc(140);
		uv_ref_cmp = 1'b0;
		cyc(5);
		chk("uv glitch", 22'h0, under_voltage_latch_r);
		uv_ref_cmp = 1'b1;
		cyc(160);
		chk("uv latch", 22'h1, under_voltage_latch_r);
		chk("uv switches", 22'h0, {hs_on, ls_on});
		chk("uv shutdown", 22'h1, soft_shutdown_req);
		uv_ref_cmp = 1'b0;
		clear_latches();
		supply_low_cmp = 1'b1;
		cyc(140);
		chk("lockout early", 22'h0, supply_lockout);
		cyc(20);
		chk("lockout", 22'h1, supply_lockout);
		chk("lockout switches", 22'h0, {hs_on, ls_on});
		supply_low_cmp = 1'b0;
		cyc(5);
		chk("lockout release", 22'h0, supply_lockout);
	endtask

	// Watchdog
	initial begin
		#200000;
		fail_count++;
		$display("Error watchdog expected finish seen hang");
		give_verdict();
	end

	// Main sequence
	initial begin
		cyc(16);
		rstn = 1'b1;
		cyc(2);
		offset_test();
		step_test();
		current_test();
		fast_test();
		ocp_test();
		ov_case(8'h40, 1'b0);
		ov_case(8'h60, 1'b1);
		uv_lock_test();
		chk("no shoot-through", 22'h0, overlap_count);
		chk("companion shutdown", 22'h1, shutdown_seen);
		give_verdict();
	end
endmodule // tb_rail_fault_protection_logic
